// ===== src/ctm_pkg.sv
// Constants, types and register map shared by the transceiver mode-control block.
// Assumes a single 40 MHz clock and synchronous supply-monitor and pin inputs.
// Behaviour
// - Two select pins choose the host-commanded state.
// - Regulator output driven except sleep; follows battery at POR.
// - Bias half, ground after silence in low-power states, floating at POR.
// - Go-to-sleep keeps regulator on while timer, wake, POR.
// - Select pins act on level changes only.
// - Mode change needs supply and I/O reference.
// - Low transmit bit drives dominant bus in normal mode only.
// - Receive bit mirrors bus while transmitting.
// - Sleep wake reported on receive bit and flag.
// - Data path supports 5 Mbit/s frames.
// - Receive bit low on dominant in normal and rx-only, low on pending wake in low-power states.
// - Fault/wake flag is active low.
// - Local wake counts on either edge.
package ctm_pkg;
	// Clock rate and timer width.
	localparam int CLK_KHZ = 40000;
	localparam int TMR_W = 17;
	// Sleep entry, bus silence and power-on settle times in microseconds.
	localparam int T_SLEEP_US = 100;
	localparam int T_SILENCE_US = 1000;
	localparam int T_PON_US = 20;
	// Least times, rounded up to whole cycles.
	localparam logic [TMR_W-1:0] SLEEP_CYC = TMR_W'((T_SLEEP_US * CLK_KHZ + 999) / 1000);
	localparam logic [TMR_W-1:0] SILENCE_CYC = TMR_W'((T_SILENCE_US * CLK_KHZ + 999) / 1000);
	localparam logic [TMR_W-1:0] PON_CYC = TMR_W'((T_PON_US * CLK_KHZ + 999) / 1000);
	// Register byte offsets.
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] MASK_OFS = 4'h8;
	localparam logic [3:0] STATE_OFS = 4'hc;
	// Control bits and reset value.
	localparam int CTRL_W = 2;
	localparam int CTRL_LWAKE_EN = 0;
	localparam int CTRL_BWAKE_EN = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;
	// Status event bits.
	localparam int EV_W = 5;
	localparam int EV_MODE = 0;
	localparam int EV_BWAKE = 1;
	localparam int EV_LWAKE = 2;
	localparam int EV_POR = 3;
	localparam int EV_IGNORED = 4;
	localparam logic [EV_W-1:0] MASK_RST = 5'h00;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Operating states and bus bias choices.
	typedef enum logic [2:0] {
		ST_POR, ST_NORMAL, ST_RXONLY, ST_STANDBY, ST_GOTOSLEEP, ST_SLEEP
	} ctm_state_type;
	typedef enum logic [1:0] {
		BIAS_FLOAT, BIAS_GND, BIAS_HALF
	} ctm_bias_type;
endpackage : ctm_pkg

// ===== src/ctm_change.sv
// Level-change detector producing a one-cycle pulse on any bit change.
// Assumes inputs already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module ctm_change #(
	parameter int W = 2
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [W-1:0] level_in,
	output logic change_out
);
	typedef struct packed {
		logic [W-1:0] prev;
		logic primed;
	} ctm_chg_type;
	ctm_chg_type s_q, s_d;

	// The first cycle only captures the level, so reset gives no false event.
	always_comb begin
		s_d = s_q;
		s_d.prev = level_in;
		s_d.primed = 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign change_out = s_q.primed && (level_in != s_q.prev);
endmodule : ctm_change
`default_nettype wire

// ===== src/ctm_timer.sv
// Down-counting timer: reloads while load is high, done once it reaches zero.
// Assumes the load value is stable while loading.
`timescale 1ns/1ps
`default_nettype none
module ctm_timer #(
	parameter int W = 17
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic load_in,
	input wire logic [W-1:0] count_in,
	output logic done_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} ctm_tmr_type;
	ctm_tmr_type s_q, s_d;

	// Reload wins over counting so a restart is never missed.
	always_comb begin
		s_d = s_q;
		if (load_in) begin
			s_d.cnt = count_in;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - W'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_out = (s_q.cnt == '0) && !load_in;
endmodule : ctm_timer
`default_nettype wire

// ===== src/ctm_top.sv
// Mode control and logic-side data path of a high-speed CAN FD transceiver,
// with an AXI4-Lite register slave and one level interrupt.
// Assumes bus comparator, wake filter and supply monitors are synchronous.
`timescale 1ns/1ps
`default_nettype none
module ctm_top #(
	parameter logic [ctm_pkg::TMR_W-1:0] SLEEP_CYCLES = ctm_pkg::SLEEP_CYC,
	parameter logic [ctm_pkg::TMR_W-1:0] SILENCE_CYCLES = ctm_pkg::SILENCE_CYC,
	parameter logic [ctm_pkg::TMR_W-1:0] PON_CYCLES = ctm_pkg::PON_CYC
) (
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	// Host-side pins.
	input wire logic MODE_PIN_IN,
	input wire logic STANDBY_SELECT_PIN_IN,
	input wire logic TX_BIT_IN,
	output logic RX_BIT_OUT,
	output logic FAULT_WAKE_FLAG_N_OUT,
	// Bus side and wake sources.
	input wire logic BUS_DOMINANT_IN,
	output logic BUS_DRIVE_DOMINANT_OUT,
	output logic [1:0] BUS_BIAS_OUT,
	input wire logic BUS_WAKE_PATTERN_IN,
	input wire logic LOCAL_WAKE_IN,
	input wire logic LOCAL_FAULT_IN,
	// Supply monitors and regulator control.
	input wire logic BATTERY_SUPPLY_OK_IN,
	input wire logic TRANSMIT_SUPPLY_OK_IN,
	input wire logic IO_SUPPLY_OK_IN,
	output logic REGULATOR_CONTROL_OUT,
	output logic REGULATOR_CONTROL_OE_OUT,
	output logic IRQ_OUT,
	// AXI4-Lite slave.
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [3:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	output logic [1:0] S_AXI_BRESP_OUT,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	input wire logic [3:0] S_AXI_ARADDR_IN,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT
);
	typedef struct packed {
		ctm_pkg::ctm_state_type st;
		logic armed;
		logic rx;
		logic flag_n;
		logic drive;
		logic [1:0] bias;
		logic reg_drv;
		logic reg_oe;
		logic wake_pend;
		logic por_flag;
		logic [ctm_pkg::EV_W-1:0] status;
		logic [ctm_pkg::EV_W-1:0] mask;
		logic [ctm_pkg::CTRL_W-1:0] ctrl;
		logic irq;
		logic aw_got;
		logic [3:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ctm_top_state_type;
	ctm_top_state_type s_q, s_d;
	logic pin_event;
	logic lwake_edge;
	logic sleep_done;
	logic silence_done;
	logic pon_done;
	logic core_ok;
	logic mode_ok;
	logic low_power;
	logic bus_wake;
	logic local_wake;
	logic [ctm_pkg::EV_W-1:0] events;
	logic [ctm_pkg::EV_W-1:0] w1c;
	logic [31:0] rd_word;
	logic rd_hit;
	logic do_write;
	// Maps a pin pair to the state it commands.
	function automatic ctm_pkg::ctm_state_type pin_state(input logic mode, input logic stby);
		ctm_pkg::ctm_state_type r;
		case ({mode, stby})
			2'b11: r = ctm_pkg::ST_NORMAL;
			2'b01: r = ctm_pkg::ST_RXONLY;
			2'b10: r = ctm_pkg::ST_GOTOSLEEP;
			default: r = ctm_pkg::ST_STANDBY;
		endcase
		return r;
	endfunction : pin_state
	// Returns a one-hot register select; zero means unmapped.
	function automatic logic [3:0] reg_sel(input logic [3:0] addr);
		logic [3:0] r;
		case (addr)
			ctm_pkg::CTRL_OFS: r = 4'h1;
			ctm_pkg::STATUS_OFS: r = 4'h2;
			ctm_pkg::MASK_OFS: r = 4'h4;
			ctm_pkg::STATE_OFS: r = 4'h8;
			default: r = 4'h0;
		endcase
		return r;
	endfunction : reg_sel
	ctm_change #(.W(2)) u_pin_change (
		.clk_in(REF_CLK_IN),
		.reset_in(RESET_IN),
		.level_in({MODE_PIN_IN, STANDBY_SELECT_PIN_IN}),
		.change_out(pin_event)
	);
	ctm_change #(.W(1)) u_wake_change (
		.clk_in(REF_CLK_IN),
		.reset_in(RESET_IN),
		.level_in(LOCAL_WAKE_IN),
		.change_out(lwake_edge)
	);
	// Sleep entry timer is reloaded on every cycle outside go-to-sleep.
	ctm_timer #(.W(ctm_pkg::TMR_W)) u_sleep_tmr (
		.clk_in(REF_CLK_IN),
		.reset_in(RESET_IN),
		.load_in(s_q.st != ctm_pkg::ST_GOTOSLEEP),
		.count_in(SLEEP_CYCLES),
		.done_out(sleep_done)
	);
	// Bus silence timer restarts on any dominant bit.
	ctm_timer #(.W(ctm_pkg::TMR_W)) u_silence_tmr (
		.clk_in(REF_CLK_IN),
		.reset_in(RESET_IN),
		.load_in(BUS_DOMINANT_IN),
		.count_in(SILENCE_CYCLES),
		.done_out(silence_done)
	);
	// Power-on settle timer holds while the core supplies are out of range.
	ctm_timer #(.W(ctm_pkg::TMR_W)) u_pon_tmr (
		.clk_in(REF_CLK_IN),
		.reset_in(RESET_IN),
		.load_in(!core_ok || !s_q.armed),
		.count_in(PON_CYCLES),
		.done_out(pon_done)
	);
	assign core_ok = BATTERY_SUPPLY_OK_IN || TRANSMIT_SUPPLY_OK_IN;
	assign mode_ok = core_ok && IO_SUPPLY_OK_IN;
	assign low_power = (s_q.st == ctm_pkg::ST_STANDBY) || (s_q.st == ctm_pkg::ST_GOTOSLEEP)
		|| (s_q.st == ctm_pkg::ST_SLEEP);
	assign bus_wake = low_power && BUS_WAKE_PATTERN_IN && s_q.ctrl[ctm_pkg::CTRL_BWAKE_EN];
	assign local_wake = low_power && lwake_edge && s_q.ctrl[ctm_pkg::CTRL_LWAKE_EN];
	// Register read mux; the state word shows the block's live condition.
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (reg_sel(S_AXI_ARADDR_IN))
			4'h1: rd_word[ctm_pkg::CTRL_W-1:0] = s_q.ctrl;
			4'h2: rd_word[ctm_pkg::EV_W-1:0] = s_q.status;
			4'h4: rd_word[ctm_pkg::EV_W-1:0] = s_q.mask;
			4'h8: rd_word[9:0] = {MODE_PIN_IN, STANDBY_SELECT_PIN_IN, mode_ok,
				s_q.por_flag, s_q.wake_pend, s_q.bias, s_q.st};
			default: rd_hit = 1'b0;
		endcase
	end
	assign do_write = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign w1c = (do_write && (reg_sel(s_q.awaddr) == 4'h2) && s_q.wstrb[0])
		? s_q.wdata[ctm_pkg::EV_W-1:0] : '0;
	// Main next-state process for mode, outputs and the register slave.
	always_comb begin
		s_d = s_q;
		s_d.armed = 1'b1;
		events = '0;
		if (s_q.st != ctm_pkg::ST_POR && pin_event && !mode_ok) begin
			events[ctm_pkg::EV_IGNORED] = 1'b1;
		end
		case (s_q.st)
			ctm_pkg::ST_POR: begin
				if (s_q.armed && pon_done) begin
					s_d.st = ctm_pkg::ST_STANDBY;
				end
			end
			ctm_pkg::ST_NORMAL, ctm_pkg::ST_RXONLY, ctm_pkg::ST_STANDBY: begin
				if (pin_event && mode_ok) begin
					s_d.st = pin_state(MODE_PIN_IN, STANDBY_SELECT_PIN_IN);
				end
			end
			ctm_pkg::ST_GOTOSLEEP: begin
				if (pin_event && mode_ok) begin
					s_d.st = pin_state(MODE_PIN_IN, STANDBY_SELECT_PIN_IN);
				// enter sleep, but a wake in this very cycle must not be lost.
				end else if (sleep_done && !s_q.wake_pend && !s_q.por_flag
					&& !bus_wake && !local_wake) begin
					s_d.st = ctm_pkg::ST_SLEEP;
				end
			end
			ctm_pkg::ST_SLEEP: begin
				if (bus_wake || local_wake) begin
					s_d.st = ctm_pkg::ST_STANDBY;
				end else if (pin_event && mode_ok
					&& pin_state(MODE_PIN_IN, STANDBY_SELECT_PIN_IN) != ctm_pkg::ST_STANDBY) begin
					s_d.st = pin_state(MODE_PIN_IN, STANDBY_SELECT_PIN_IN);
				end
			end
			default: s_d.st = ctm_pkg::ST_POR;
		endcase
		// Losing both core supplies forces power-on reset from any state.
		if (!core_ok) begin
			s_d.st = ctm_pkg::ST_POR;
		end
		// Wake pending: a new wake wins over the clear on reaching an active mode.
		if (s_d.st == ctm_pkg::ST_NORMAL || s_d.st == ctm_pkg::ST_RXONLY) begin
			s_d.wake_pend = 1'b0;
		end
		if (bus_wake || local_wake) begin
			s_d.wake_pend = 1'b1;
		end
		// The power-on flag stays set until the host reaches normal mode.
		if (s_d.st == ctm_pkg::ST_NORMAL) begin
			s_d.por_flag = 1'b0;
		end
		if (s_d.st == ctm_pkg::ST_POR) begin
			s_d.por_flag = 1'b1;
		end
		events[ctm_pkg::EV_MODE] = (s_d.st != s_q.st);
		events[ctm_pkg::EV_BWAKE] = bus_wake;
		events[ctm_pkg::EV_LWAKE] = local_wake;
		events[ctm_pkg::EV_POR] = (s_d.st == ctm_pkg::ST_POR) && (s_q.st != ctm_pkg::ST_POR);
		s_d.drive = (s_d.st == ctm_pkg::ST_NORMAL) && !TX_BIT_IN;
		// Receive bit and flag per state; registered once, well inside a 5 Mbit/s bit.
		case (s_d.st)
			ctm_pkg::ST_NORMAL: begin
				s_d.rx = !BUS_DOMINANT_IN;
				s_d.flag_n = !LOCAL_FAULT_IN;
			end
			ctm_pkg::ST_RXONLY: begin
				s_d.rx = !BUS_DOMINANT_IN;
				s_d.flag_n = !s_q.por_flag;
			end
			ctm_pkg::ST_STANDBY, ctm_pkg::ST_GOTOSLEEP, ctm_pkg::ST_SLEEP: begin
				s_d.rx = !s_d.wake_pend;
				s_d.flag_n = !s_d.wake_pend;
			end
			default: begin
				s_d.rx = 1'b1;
				s_d.flag_n = 1'b1;
			end
		endcase
		case (s_d.st)
			ctm_pkg::ST_POR: begin
				s_d.reg_drv = BATTERY_SUPPLY_OK_IN;
				s_d.reg_oe = 1'b1;
			end
			ctm_pkg::ST_SLEEP: begin
				s_d.reg_drv = 1'b0;
				s_d.reg_oe = 1'b0;
			end
			ctm_pkg::ST_GOTOSLEEP: begin
				s_d.reg_oe = !sleep_done || s_d.wake_pend || s_d.por_flag;
				s_d.reg_drv = s_d.reg_oe;
			end
			default: begin
				s_d.reg_drv = 1'b1;
				s_d.reg_oe = 1'b1;
			end
		endcase

		case (s_d.st)
			ctm_pkg::ST_POR: s_d.bias = ctm_pkg::BIAS_FLOAT;
			ctm_pkg::ST_NORMAL, ctm_pkg::ST_RXONLY: s_d.bias = ctm_pkg::BIAS_HALF;
			default: s_d.bias = silence_done ? ctm_pkg::BIAS_GND : ctm_pkg::BIAS_HALF;
		endcase

		// Write address and data are taken in either order and held until answered.
		if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
			s_d.w_got = 1'b1;
			s_d.wdata = S_AXI_WDATA_IN;
			s_d.wstrb = S_AXI_WSTRB_IN;
		end
		if (do_write) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = (reg_sel(s_q.awaddr) == 4'h0) ? ctm_pkg::RESP_SLVERR : ctm_pkg::RESP_OKAY;
			if (s_q.wstrb[0] && reg_sel(s_q.awaddr) == 4'h1) begin
				s_d.ctrl = s_q.wdata[ctm_pkg::CTRL_W-1:0];
			end
			if (s_q.wstrb[0] && reg_sel(s_q.awaddr) == 4'h4) begin
				s_d.mask = s_q.wdata[ctm_pkg::EV_W-1:0];
			end
		end
		if (s_q.bvalid && S_AXI_BREADY_IN) begin
			s_d.bvalid = 1'b0;
		end

		// Sticky events: a set in the same cycle as its clear is kept.
		s_d.status = (s_q.status & ~w1c) | events;
		s_d.irq = |(s_d.status & s_d.mask);

		// Reads answer one cycle after the address is taken.
		if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_word;
			s_d.rresp = rd_hit ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR;
		end else if (s_q.rvalid && S_AXI_RREADY_IN) begin
			s_d.rvalid = 1'b0;
		end
	end

	// State register with synchronous reset to power-on reset.
	always_ff @(posedge REF_CLK_IN) begin
		if (RESET_IN) begin
			s_q <= '0;
			s_q.st <= ctm_pkg::ST_POR;
			s_q.rx <= 1'b1;
			s_q.flag_n <= 1'b1;
			s_q.reg_oe <= 1'b1;
			s_q.bias <= ctm_pkg::BIAS_FLOAT;
			s_q.por_flag <= 1'b1;
			s_q.ctrl <= ctm_pkg::CTRL_RST;
			s_q.mask <= ctm_pkg::MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs, all straight from the state register apart from handshake readies.
	assign RX_BIT_OUT = s_q.rx;
	assign FAULT_WAKE_FLAG_N_OUT = s_q.flag_n;
	assign BUS_DRIVE_DOMINANT_OUT = s_q.drive;
	assign BUS_BIAS_OUT = s_q.bias;
	assign REGULATOR_CONTROL_OUT = s_q.reg_drv;
	assign REGULATOR_CONTROL_OE_OUT = s_q.reg_oe;
	assign IRQ_OUT = s_q.irq;
	assign S_AXI_AWREADY_OUT = !s_q.aw_got && !s_q.bvalid;
	assign S_AXI_WREADY_OUT = !s_q.w_got && !s_q.bvalid;
	assign S_AXI_BVALID_OUT = s_q.bvalid;
	assign S_AXI_BRESP_OUT = s_q.bresp;
	assign S_AXI_ARREADY_OUT = !s_q.rvalid;
	assign S_AXI_RVALID_OUT = s_q.rvalid;
	assign S_AXI_RDATA_OUT = s_q.rdata;
	assign S_AXI_RRESP_OUT = s_q.rresp;
endmodule : ctm_top
`default_nettype wire

// ===== verif/ctm_top_sva.sv
// Concurrent checks on the pins and register handshake of the mode-control block.
// Assumes one clock and a synchronous active-high reset; bound into every ctm_top.
`timescale 1ns/1ps
`default_nettype none
module ctm_top_sva (
	input wire logic REF_CLK_IN,
	input wire logic RESET_IN,
	input wire logic MODE_PIN_IN,
	input wire logic STANDBY_SELECT_PIN_IN,
	input wire logic TX_BIT_IN,
	input wire logic RX_BIT_OUT,
	input wire logic FAULT_WAKE_FLAG_N_OUT,
	input wire logic BUS_DOMINANT_IN,
	input wire logic BUS_DRIVE_DOMINANT_OUT,
	input wire logic [1:0] BUS_BIAS_OUT,
	input wire logic LOCAL_WAKE_IN,
	input wire logic BATTERY_SUPPLY_OK_IN,
	input wire logic REGULATOR_CONTROL_OUT,
	input wire logic REGULATOR_CONTROL_OE_OUT,
	input wire logic S_AXI_AWREADY_OUT,
	input wire logic S_AXI_WREADY_OUT,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic S_AXI_RREADY_IN
);
	// Every check runs on the core clock and rests while reset is held.
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (RESET_IN);

	tx_path_a: assert property (BUS_DRIVE_DOMINANT_OUT |-> !$past(TX_BIT_IN))
		else $error("Bus driven dominant without a low transmit bit.");
	rx_mirror_a: assert property (BUS_DRIVE_DOMINANT_OUT && BUS_DOMINANT_IN &&
		$stable({MODE_PIN_IN, STANDBY_SELECT_PIN_IN}) |=> !RX_BIT_OUT)
		else $error("Receive bit not low while own dominant bit is on the bus.");
	drive_reg_a: assert property (BUS_DRIVE_DOMINANT_OUT |->
		REGULATOR_CONTROL_OE_OUT && REGULATOR_CONTROL_OUT)
		else $error("Regulator not driven while transmitting.");
	drive_bias_a: assert property (BUS_DRIVE_DOMINANT_OUT |-> BUS_BIAS_OUT == 2'h2)
		else $error("Bus bias not half supply while transmitting.");
	// Sleep may only be taken with no wake pending, so both flags were high before.
	oe_fall_a: assert property ($fell(REGULATOR_CONTROL_OE_OUT) |->
		$past(RX_BIT_OUT) && $past(FAULT_WAKE_FLAG_N_OUT))
		else $error("Regulator released while a wake was pending.");
	local_wake_a: assert property (!REGULATOR_CONTROL_OE_OUT && BATTERY_SUPPLY_OK_IN &&
		$changed(LOCAL_WAKE_IN) |-> ##[1:2] (!RX_BIT_OUT && !FAULT_WAKE_FLAG_N_OUT))
		else $error("Local wake edge in sleep not reported.");
	write_block_a: assert property (S_AXI_BVALID_OUT |->
		!S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
		else $error("Write accepted while a response is outstanding.");
	read_block_a: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
		else $error("Read accepted while read data is outstanding.");
	// An answer may only be withdrawn at an edge where the master takes it.
	write_hold_a: assert property ($fell(S_AXI_BVALID_OUT) |-> $past(S_AXI_BREADY_IN))
		else $error("Write response withdrawn before it was taken.");
	read_hold_a: assert property ($fell(S_AXI_RVALID_OUT) |-> $past(S_AXI_RREADY_IN))
		else $error("Read data withdrawn before it was taken.");
endmodule : ctm_top_sva

bind ctm_top ctm_top_sva u_sva (
	.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .MODE_PIN_IN(MODE_PIN_IN),
	.STANDBY_SELECT_PIN_IN(STANDBY_SELECT_PIN_IN), .TX_BIT_IN(TX_BIT_IN),
	.RX_BIT_OUT(RX_BIT_OUT), .FAULT_WAKE_FLAG_N_OUT(FAULT_WAKE_FLAG_N_OUT),
	.BUS_DOMINANT_IN(BUS_DOMINANT_IN), .BUS_DRIVE_DOMINANT_OUT(BUS_DRIVE_DOMINANT_OUT),
	.BUS_BIAS_OUT(BUS_BIAS_OUT), .LOCAL_WAKE_IN(LOCAL_WAKE_IN),
	.BATTERY_SUPPLY_OK_IN(BATTERY_SUPPLY_OK_IN), .REGULATOR_CONTROL_OUT(REGULATOR_CONTROL_OUT),
	.REGULATOR_CONTROL_OE_OUT(REGULATOR_CONTROL_OE_OUT), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
	.S_AXI_WREADY_OUT(S_AXI_WREADY_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
	.S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT),
	.S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_RREADY_IN(S_AXI_RREADY_IN)
);
`default_nettype wire

// ===== verif/ctm_host_model.sv
// Host-side CAN controller model driving the select pins and transmit bit, plus a lone-node bus.
// Assumes the testbench states the wanted pin pair and bit; the model launches them on the clock.
`timescale 1ns/1ps
`default_nettype none
module ctm_host_model (
	input wire logic clk_in,
	input wire logic [1:0] mode_req_in,
	input wire logic tx_req_in,
	input wire logic drive_dominant_in,
	output logic mode_pin_out,
	output logic standby_pin_out,
	output logic tx_bit_out,
	output logic bus_dominant_out
);
	logic [2:0] pins_q = 3'h1;

	// select pin pair and transmit bit
	// Pins change just after an edge so the block sees one clean level per cycle.
	always @(posedge clk_in) begin
		pins_q <= {mode_req_in, tx_req_in};
	end
	assign mode_pin_out = pins_q[2];
	assign standby_pin_out = pins_q[1];
	assign tx_bit_out = pins_q[0];
	// With no other node, the wire is dominant exactly while this node drives it.
	assign bus_dominant_out = drive_dominant_in;
endmodule : ctm_host_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking testbench for the transceiver mode-control block with shortened timers.
// Assumes the bound checker and the host model; registers are reached over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rst, tx_req, lwake, batt, io, mpin, spin, txb, rxb, flag_n, bus_dom, drv;
	logic reg_o, reg_oe, irq, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, fault, bwake;
	logic [1:0] mode_req, bias, bresp, rresp, rsp;
	logic [3:0] awa, ara;
	logic [31:0] wd, rd, rdata;
	logic [1:0] modes [3] = '{2'h1, 2'h0, 2'h3};
	logic [2:0] states [3] = '{3'h2, 3'h3, 3'h1};
	int miscompares, checks_done;

	ctm_host_model u_host (.clk_in(clk), .mode_req_in(mode_req), .tx_req_in(tx_req),
		.drive_dominant_in(drv), .mode_pin_out(mpin), .standby_pin_out(spin),
		.tx_bit_out(txb), .bus_dominant_out(bus_dom));
	ctm_top #(.SLEEP_CYCLES(17'h00014), .SILENCE_CYCLES(17'h00032), .PON_CYCLES(17'h0000a)) u_dut (
		.REF_CLK_IN(clk), .RESET_IN(rst), .MODE_PIN_IN(mpin), .STANDBY_SELECT_PIN_IN(spin),
		.TX_BIT_IN(txb), .RX_BIT_OUT(rxb), .FAULT_WAKE_FLAG_N_OUT(flag_n),
		.BUS_DOMINANT_IN(bus_dom), .BUS_DRIVE_DOMINANT_OUT(drv), .BUS_BIAS_OUT(bias),
		.BUS_WAKE_PATTERN_IN(bwake), .LOCAL_WAKE_IN(lwake), .LOCAL_FAULT_IN(fault),
		.BATTERY_SUPPLY_OK_IN(batt), .TRANSMIT_SUPPLY_OK_IN(batt), .IO_SUPPLY_OK_IN(io),
		.REGULATOR_CONTROL_OUT(reg_o), .REGULATOR_CONTROL_OE_OUT(reg_oe), .IRQ_OUT(irq),
		.S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa),
		.S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr), .S_AXI_WDATA_IN(wd),
		.S_AXI_WSTRB_IN(4'hf), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
		.S_AXI_ARADDR_IN(ara), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
		.S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp));

	// The 40 MHz core clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Compares one value and reports a mismatch at once.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Waits on falling edges so that outputs are settled when looked at.
	task waitn(input int n);
		repeat (n) @(negedge clk);
	endtask : waitn

	// AXI4-Lite write: address and data offered together, each released once taken.
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, got;
		got = 1'b0;
		@(posedge clk);
		awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; br <= 1'b1;
		while (!got) begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wr;
			got = bv;
			rsp = bresp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		br <= 1'b0;
	endtask : wr_reg

	// AXI4-Lite read: data and response are captured in the cycle they are taken.
	task rd_reg(input logic [3:0] a);
		logic ta, got;
		got = 1'b0;
		@(posedge clk);
		arv <= 1'b1; ara <= a; rr <= 1'b1;
		while (!got) begin
			@(negedge clk);
			ta = arv && arr;
			got = rv;
			rdata = rd;
			rsp = rresp;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end
		rr <= 1'b0;
	endtask : rd_reg

	// Prints the verdict and ends the run.
	task finish_test;
		if (miscompares == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// The sequence takes about 220 cycles; some nine times that means a hang.
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		finish_test();
	end

	initial begin
		rst = 1'b1; mode_req = 2'h0; tx_req = 1'b1; lwake = 1'b0; batt = 1'b1; io = 1'b1;
		awv = 1'b0; wv = 1'b0; awa = 4'h0; wd = 32'h0; br = 1'b0; arv = 1'b0; ara = 4'h0;
		rr = 1'b0; fault = 1'b0; bwake = 1'b0; miscompares = 0; checks_done = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		waitn(20);
		chk({30'h0, rxb, flag_n}, 32'h3);
		rd_reg(4'hc);
		chk(rdata & 32'h7, 32'h3);
		rd_reg(4'h0);
		chk(rdata, 32'h3);
		rd_reg(4'h8);
		chk(rdata, 32'h0);
		// Walk rx-only, standby and normal through the pin pairs.
		for (int i = 0; i < 3; i++) begin
			mode_req <= modes[i];
			waitn(4);
			chk(32'(reg_oe), 32'h1);
			if (i != 1) chk(32'(bias), 32'h2);
			rd_reg(4'hc);
			chk(rdata & 32'h7, 32'(states[i]));
		end
		// Own dominant bit must come back on the receive bit while sending.
		tx_req <= 1'b0;
		waitn(4);
		chk(32'(drv), 32'h1);
		chk(32'(rxb), 32'h0);
		@(posedge clk);
		tx_req <= 1'b1;
		waitn(4);
		chk(32'(rxb), 32'h1);
		// A local failure in normal mode pulls the flag low.
		@(posedge clk);
		fault <= 1'b1;
		waitn(2);
		chk(32'(flag_n), 32'h0);
		// A pin event with the reference supply out of range is dropped for good.
		@(posedge clk);
		fault <= 1'b0;
		io <= 1'b0;
		mode_req <= 2'h1;
		waitn(4);
		rd_reg(4'hc);
		chk(rdata & 32'h7, 32'h1);
		io <= 1'b1;
		waitn(4);
		rd_reg(4'hc);
		chk(rdata & 32'h7, 32'h1);
		rd_reg(4'h4);
		chk(rdata & 32'h10, 32'h10);
		wr_reg(4'h4, 32'h1f);
		rd_reg(4'h4);
		chk(rdata, 32'h0);
		wr_reg(4'h8, 32'h4);
		chk(32'(rsp), 32'h0);
		// Go-to-sleep, then sleep once the shortened timer has run out.
		mode_req <= 2'h2;
		waitn(4);
		rd_reg(4'hc);
		chk(rdata & 32'h7, 32'h4);
		waitn(30);
		chk(32'(reg_oe), 32'h0);
		rd_reg(4'hc);
		chk(rdata & 32'h7, 32'h5);
		waitn(60);
		chk(32'(bias), 32'h1);
		chk(32'(irq), 32'h0);
		// A rising local wake edge leaves sleep and raises the unmasked interrupt.
		@(posedge clk);
		lwake <= 1'b1;
		waitn(3);
		chk({30'h0, rxb, flag_n}, 32'h0);
		chk(32'(irq), 32'h1);
		rd_reg(4'hc);
		chk(rdata & 32'h7, 32'h3);
		wr_reg(4'h4, 32'h1f);
		waitn(2);
		chk(32'(irq), 32'h0);
		rd_reg(4'h2);
		chk(32'(rsp), 32'h2);
		wr_reg(4'h2, 32'h0);
		chk(32'(rsp), 32'h2);
		// A bus wake pattern in standby is logged as its own event.
		@(posedge clk);
		bwake <= 1'b1;
		@(posedge clk);
		bwake <= 1'b0;
		rd_reg(4'h4);
		chk(rdata & 32'h2, 32'h2);
		// Loss of both core supplies forces power-on reset.
		batt <= 1'b0;
		waitn(3);
		chk({29'h0, reg_o, bias}, 32'h0);
		rd_reg(4'hc);
		chk(rdata & 32'h7, 32'h0);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
